/* logic/uotg_defs.vh */
// Constants for the USB OTG interrupt flag and enable block.
// Assumes a plain register port with byte addresses, 32-bit data.
`ifndef UOTG_DEFS_VH
`define UOTG_DEFS_VH

// Register byte addresses
`define UOTG_ADDR_EVENT 8'h00
`define UOTG_ADDR_EVMASK 8'h04
`define UOTG_ADDR_ENABLE 8'h08
`define UOTG_ADDR_USBSTAT 8'h0C

// Event register bit positions
`define UOTG_BIT_ID 7
`define UOTG_BIT_MS 6
`define UOTG_BIT_LSTATE 5
`define UOTG_BIT_ACTV 4
`define UOTG_BIT_SESVD 3
`define UOTG_BIT_SESEND 2
`define UOTG_BIT_VBUSVD 0
`define UOTG_EVENT_IMPL 8'hFD

// Enable register bit positions
`define UOTG_BIT_STALL 7
`define UOTG_BIT_ATTACH 6
`define UOTG_BIT_RESUME 5
`define UOTG_BIT_IDLE 4
`define UOTG_BIT_TOKEN 3
`define UOTG_BIT_SOF 2
`define UOTG_BIT_UERR 1
`define UOTG_BIT_RST 0

// Reset values
`define UOTG_RST_BYTE 8'h00

// Timing: 1 ms at 25 MHz (40 ns period)
`define UOTG_MS_NS 1000000
`define UOTG_CLK_NS 40
`define UOTG_MS_CYCLES (`UOTG_MS_NS / `UOTG_CLK_NS)
`define UOTG_CNT_W 15

`endif

/* logic/uotg_irq.v */
// USB OTG event flags, USB interrupt enables and summary interrupts.
// Assumes single-cycle strobes from a master on i_sys_clk, and raw
// line/VBUS inputs that are asynchronous to it.
//
// The plain strobed port and the address map are this design's own decisions.
`default_nettype none
`include "uotg_defs.vh"

// Summary of operation
// - ID pin change sets event bit 7.
// - Each 1 ms timer expiry sets event bit 6.
// - Line state stable 1 ms and new sets event bit 5.
// - Wake activity on D+, D-, ID or VBUS sets event bit 4.
// - VBUS falling below session end sets event bit 3.
// - Any change on session end input sets event bit 2.
// - Any change on session valid input sets event bit 0.
// - Only hardware sets flags; writing one clears, zero keeps.
// - Bits 31-8 read zero in both registers; event bit 1 reads zero.
// - Enable bit 7 gates the stall interrupt.
// - Enable bit 6 gates the attach interrupt.
// - Enable bit 5 gates the resume interrupt.
// - Enable bit 4 gates the idle-detect interrupt.
// - Enable bit 3 gates the token-done interrupt.
// - Enable bit 2 gates the start-of-frame interrupt.
// - Error interrupt reaches summary only with enable bit 1 set.
// - Enable bit 0 gates bus reset as device, detach as host.
// - Enable bits are read/write and reset to zero.
module uotg_irq (
    // Clock and reset
    input wire i_sys_clk,
    input wire i_rst,
    // Register port
    input wire [7:0] i_addr,
    input wire [31:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [31:0] o_rdata,
    // OTG line and VBUS detectors, asynchronous
    input wire i_id_pin,
    input wire [1:0] i_line_state,
    input wire i_wake_activity,
    input wire i_session_end,
    input wire i_session_valid,
    input wire i_vbus_below_end,
    // USB core event pulses, same clock
    input wire i_stall_evt,
    input wire i_attach_evt,
    input wire i_resume_evt,
    input wire i_idle_evt,
    input wire i_token_done_evt,
    input wire i_frame_start_evt,
    input wire i_usb_error_evt,
    input wire i_bus_reset_evt,
    input wire i_detach_evt,
    input wire i_host_mode,
    // Interrupt outputs
    output reg o_otg_irq,
    output reg o_usb_summary_irq
);

    // Read data masked to the implemented bits of a register
    function [31:0] uotg_rd_word;
        input [7:0] value;
        input [7:0] impl;
        begin
            uotg_rd_word = {24'h00_0000, value & impl};
        end
    endfunction

    // Two-flop synchronisers: stage one is read only by stage two
    reg [6:0] sync_a;
    reg [6:0] sync_b;
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            sync_a <= 7'h00;
            sync_b <= 7'h00;
        end else begin
            sync_a <= {i_id_pin, i_line_state, i_wake_activity,
                       i_session_end, i_session_valid, i_vbus_below_end};
            sync_b <= sync_a;
        end
    end

    wire s_id = sync_b[6];
    wire [1:0] s_line = sync_b[5:4];
    wire s_wake = sync_b[3];
    wire s_send = sync_b[2];
    wire s_svalid = sync_b[1];
    wire s_below = sync_b[0];

    // Previous synchronised levels for edge detection
    reg [5:0] prev;
    reg [1:0] fill_cnt;
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            prev <= 6'h00;
            fill_cnt <= 2'h0;
        end else begin
            prev <= {s_id, s_wake, s_send, s_svalid, s_below, 1'b0};
            if (fill_cnt != 2'h3) begin
                fill_cnt <= fill_cnt + 2'h1;
            end
        end
    end

    // Edges are masked until both sync stages and prev hold real pin
    // levels (three edges), otherwise a strap-high pin fakes a change.
    wire prev_valid = (fill_cnt == 2'h3);
    wire id_chg = prev_valid & (s_id ^ prev[5]);
    wire wake_rise = prev_valid & s_wake & ~prev[4];
    wire send_chg = prev_valid & (s_send ^ prev[3]);
    wire svalid_chg = prev_valid & (s_svalid ^ prev[2]);
    wire below_rise = prev_valid & s_below & ~prev[1];

    reg [`UOTG_CNT_W-1:0] ms_cnt;
    reg ms_tick;
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            ms_cnt <= {`UOTG_CNT_W{1'b0}};
            ms_tick <= 1'b0;
        end else if (ms_cnt == `UOTG_MS_CYCLES - 1) begin
            ms_cnt <= {`UOTG_CNT_W{1'b0}};
            ms_tick <= 1'b1;
        end else begin
            ms_cnt <= ms_cnt + 1'b1;
            ms_tick <= 1'b0;
        end
    end

    // line state stability filter
    // Restarts on every line change; reports once per new stable state.
    reg [1:0] line_seen;
    reg [1:0] line_stable;
    reg [`UOTG_CNT_W-1:0] line_cnt;
    reg line_evt;
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            line_seen <= 2'h0;
            line_stable <= 2'h0;
            line_cnt <= {`UOTG_CNT_W{1'b0}};
            line_evt <= 1'b0;
        end else begin
            line_seen <= s_line;
            line_evt <= 1'b0;
            if (s_line != line_seen) begin
                line_cnt <= {`UOTG_CNT_W{1'b0}};
            end else if (line_cnt != `UOTG_MS_CYCLES - 1) begin
                line_cnt <= line_cnt + 1'b1;
            end else if (line_seen != line_stable) begin
                line_stable <= line_seen;
                line_evt <= 1'b1;
            end
        end
    end

    // Hardware set vector for the event register
    reg [7:0] evt_set;
    always @* begin
        evt_set = 8'h00;
        evt_set[`UOTG_BIT_ID] = id_chg;
        evt_set[`UOTG_BIT_MS] = ms_tick;
        evt_set[`UOTG_BIT_LSTATE] = line_evt;
        evt_set[`UOTG_BIT_ACTV] = wake_rise;
        evt_set[`UOTG_BIT_SESVD] = below_rise;
        evt_set[`UOTG_BIT_SESEND] = send_chg;
        evt_set[`UOTG_BIT_VBUSVD] = svalid_chg;
    end

    wire wr_event = i_wr & (i_addr == `UOTG_ADDR_EVENT);
    wire wr_evmask = i_wr & (i_addr == `UOTG_ADDR_EVMASK);
    wire wr_enable = i_wr & (i_addr == `UOTG_ADDR_ENABLE);
    wire rd_usbstat = i_rd & (i_addr == `UOTG_ADDR_USBSTAT);

    reg [7:0] otg_event_flags;
    reg [7:0] otg_event_mask;
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            otg_event_flags <= `UOTG_RST_BYTE;
            otg_event_mask <= `UOTG_RST_BYTE;
        end else begin
            otg_event_flags <= ((otg_event_flags &
                ~(wr_event ? i_wdata[7:0] : 8'h00)) | evt_set)
                & `UOTG_EVENT_IMPL;
            if (wr_evmask) begin
                otg_event_mask <= i_wdata[7:0] & `UOTG_EVENT_IMPL;
            end
        end
    end

    reg [7:0] usb_irq_enable_mask;
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            usb_irq_enable_mask <= `UOTG_RST_BYTE;
        end else if (wr_enable) begin
            usb_irq_enable_mask <= i_wdata[7:0];
        end
    end

    // Bit 0 source follows the role: bus reset as device, detach as host
    reg [7:0] usb_set;
    always @* begin
        usb_set = 8'h00;
        usb_set[`UOTG_BIT_STALL] = i_stall_evt;
        usb_set[`UOTG_BIT_ATTACH] = i_attach_evt;
        usb_set[`UOTG_BIT_RESUME] = i_resume_evt;
        usb_set[`UOTG_BIT_IDLE] = i_idle_evt;
        usb_set[`UOTG_BIT_TOKEN] = i_token_done_evt;
        usb_set[`UOTG_BIT_SOF] = i_frame_start_evt;
        usb_set[`UOTG_BIT_UERR] = i_usb_error_evt;
        usb_set[`UOTG_BIT_RST] = i_host_mode ? i_detach_evt
                                             : i_bus_reset_evt;
    end

    // Sticky USB event status, cleared by a read; set wins over clear
    reg [7:0] usb_status;
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            usb_status <= `UOTG_RST_BYTE;
        end else begin
            usb_status <= (rd_usbstat ? 8'h00 : usb_status) | usb_set;
        end
    end

    // per-source gating by the enable register
    wire [7:0] usb_pending = usb_status & usb_irq_enable_mask;

    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_usb_summary_irq <= 1'b0;
            o_otg_irq <= 1'b0;
        end else begin
            o_usb_summary_irq <= |usb_pending;
            o_otg_irq <= |(otg_event_flags & otg_event_mask);
        end
    end

    // read mux, unimplemented bits zero, unmapped reads zero
    always @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            case (i_addr)
                `UOTG_ADDR_EVENT:
                    o_rdata <= uotg_rd_word(otg_event_flags,
                                            `UOTG_EVENT_IMPL);
                `UOTG_ADDR_EVMASK:
                    o_rdata <= uotg_rd_word(otg_event_mask,
                                            `UOTG_EVENT_IMPL);
                `UOTG_ADDR_ENABLE:
                    o_rdata <= uotg_rd_word(usb_irq_enable_mask, 8'hFF);
                `UOTG_ADDR_USBSTAT:
                    o_rdata <= uotg_rd_word(usb_status, 8'hFF);
                default:
                    o_rdata <= 32'h0000_0000;
            endcase
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

endmodule // uotg_irq
`default_nettype wire

/* tb/uotg_irq_asserts.sv */
// Port checker for the OTG flag and USB interrupt enable block.
// Assumes the register map and bit layout of the shared header.
`default_nettype none
`include "uotg_defs.vh"
module uotg_irq_asserts (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    // Sources
    input wire logic i_session_valid,
    input wire logic i_usb_error_evt,
    // Interrupts
    input wire logic o_otg_irq,
    input wire logic o_usb_summary_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] en;
    logic [7:0] mk;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // Shadow enables and mask, so we know which sources may fire
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            en <= 8'h00;
            mk <= 8'h00;
        end else if (i_wr && i_addr == `UOTG_ADDR_ENABLE) begin
            en <= i_wdata[7:0];
        end else if (i_wr && i_addr == `UOTG_ADDR_EVMASK) begin
            mk <= i_wdata[7:0];
        end
    end
    sequence en_wr_s;
        i_wr && i_addr == `UOTG_ADDR_ENABLE;
    endsequence
    sequence en_rd_s;
        !i_wr ##1 i_rd && i_addr == `UOTG_ADDR_ENABLE;
    endsequence
    // Read clears status, so the window holds no read strobe in either cycle and no write in the second, when summary samples status
    sequence err_s;
        i_usb_error_evt && en[1] && !i_rd ##1 !i_rd && !i_wr;
    endsequence
    upper_zero_a: assert property (o_rdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    gap_bit_a: assert property ($past(i_rd) &&
        $past(i_addr) == `UOTG_ADDR_EVENT |-> !o_rdata[1])
        else $error("event bit 1 read as one");
    en_back_a: assert property (en_wr_s ##1 en_rd_s |=>
        o_rdata == ($past(i_wdata, 3) & 32'h0000_00FF))
        else $error("enable read back differs");
    err_raise_a: assert property (err_s |=> o_usb_summary_irq)
        else $error("enabled error gave no summary");
    sum_block_a: assert property (en == 8'h00 && $past(en) == 8'h00
        |-> !o_usb_summary_irq) else $error("summary while all disabled");
    sum_fall_a: assert property ($fell(o_usb_summary_irq) |->
        $past(i_rd) || $past(i_rd, 2) || $past(i_rd, 3) || $past(i_wr)
        || $past(i_wr, 2) || $past(i_wr, 3)) else $error("summary fell");
    otg_fall_a: assert property ($fell(o_otg_irq) |->
        $past(i_wr) || $past(i_wr, 2) || $past(i_wr, 3))
        else $error("event flag dropped without write");
    vbus_raise_a: assert property ($changed(i_session_valid) && mk[0]
        |-> ##[1:6] o_otg_irq) else $error("session valid change lost");
endmodule // uotg_irq_asserts
`default_nettype wire

/* tb/uotg_irq_test.sv */
// Self-checking bench for the OTG event flags and USB enables.
// Assumes read data stand only in the cycle after the read strobe.
`default_nettype none
`include "uotg_defs.vh"
`define CHK(n, e, g) cmp(n, e, g)
module uotg_irq_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_host_mode = 1'b0;
    logic rd_q = 1'b0;
    logic o_otg_irq;
    logic o_usb_summary_irq;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic [31:0] o_rdata;
    logic [31:0] seed = 32'h0000_A845;
    logic [31:0] exp_q[$];
    logic [8:0] ev;
    logic [6:0] lv;
    int lv_idx[5] = '{0, 4, 5, 6, 3};
    int ev_bit[5] = '{7, 2, 0, 3, 4};
    int num_errors = 0;
    int num_checks = 0;
    // System clock, 40 ns period
    always #20 i_sys_clk = ~i_sys_clk;
    uotg_irq uotg_irq_inst (.i_sys_clk, .i_rst, .i_addr, .i_wdata, .i_wr,
        .i_rd, .o_rdata, .i_id_pin(lv[0]), .i_line_state(lv[2:1]),
        .i_wake_activity(lv[3]), .i_session_end(lv[4]),
        .i_session_valid(lv[5]), .i_vbus_below_end(lv[6]),
        .i_stall_evt(ev[8]), .i_attach_evt(ev[7]), .i_resume_evt(ev[6]),
        .i_idle_evt(ev[5]), .i_token_done_evt(ev[4]),
        .i_frame_start_evt(ev[3]), .i_usb_error_evt(ev[2]),
        .i_bus_reset_evt(ev[1]), .i_detach_evt(ev[0]), .i_host_mode,
        .o_otg_irq, .o_usb_summary_irq);
    uotg_phy_model uotg_phy_model_inst (.i_sys_clk, .o_evt(ev), .o_lvl(lv));
    task automatic cmp(input string n, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask
    // Read notes its expectation; the monitor below compares it
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_sys_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        exp_q.push_back(e);
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
    endtask
    // Read data stand one cycle after the strobe
    always @(posedge i_sys_clk) begin
        if (rd_q) `CHK("rdata", exp_q.pop_front(), o_rdata);
        rd_q <= i_rd;
    end
    // Main sequence
    initial begin
        int b;
        repeat (20) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        for (int a = 0; a < 20; a += 4) rd(8'(a), 32'h0000_0000);
        b = rnd();
        wr(`UOTG_ADDR_ENABLE, b);
        rd(`UOTG_ADDR_ENABLE, b & 32'h0000_00FF);
        $display("end of register test");
        for (int m = 0; m < 2; m++) begin
            for (int n = 0; n < 9; n++) begin
                b = n ? n - 1 : 0;
                i_host_mode <= (n == 0);
                // Only the source's own enable bit, or all but it
                wr(`UOTG_ADDR_ENABLE, m ? 32'h0000_0001 << b
                                        : 32'h0000_00FF ^ (32'h0000_0001 << b));
                uotg_phy_model_inst.pulse(n);
                @(posedge i_sys_clk);
                #1 `CHK("summary", m, o_usb_summary_irq);
                rd(8'h0C, 32'h0000_0001 << b);
            end
        end
        $display("end of core event test");
        wr(`UOTG_ADDR_EVMASK, 32'h0000_00FF);
        for (int i = 0; i < 5; i++) begin
            wr(`UOTG_ADDR_EVENT, 32'hFFFF_FFFF);
            uotg_phy_model_inst.flip(lv_idx[i]);
            repeat (6) @(posedge i_sys_clk);
            `CHK("otg", 1, o_otg_irq);
            wr(`UOTG_ADDR_EVENT, 32'h0000_0000);
            rd(`UOTG_ADDR_EVENT, 32'h0000_0001 << ev_bit[i]);
        end
        wr(`UOTG_ADDR_EVENT, 32'hFFFF_FFFF);
        rd(`UOTG_ADDR_EVENT, 32'h0000_0000);
        $display("end of detector test");
        uotg_phy_model_inst.flip(1);
        repeat (26000) @(posedge i_sys_clk);
        rd(`UOTG_ADDR_EVENT, 32'h0000_0060);
        $display("end of timer test");
        // Mid-run reset with pins held high: no false edge may follow
        i_rst <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        repeat (6) @(posedge i_sys_clk);
        rd(`UOTG_ADDR_EVENT, 32'h0000_0000);
        $display("end of reset test");
        end_sim();
    end
    // Hang guard counts as a mismatch
    initial begin
        repeat (40000) @(posedge i_sys_clk);
        num_errors++;
        end_sim();
    end
endmodule // uotg_irq_test
bind uotg_irq uotg_irq_asserts uotg_irq_asserts_inst (.i_sys_clk, .i_rst,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_session_valid,
    .i_usb_error_evt, .o_otg_irq, .o_usb_summary_irq);
`default_nettype wire

/* tb/uotg_phy_model.sv */
// Far-side model: USB core event pulses and OTG detector levels.
// Assumes the bench calls its tasks from the clocked main sequence.
`default_nettype none
module uotg_phy_model (
    // Clock
    input wire logic i_sys_clk,
    // Core pulses: 8 stall .. 2 error, 1 bus reset, 0 detach
    output var logic [8:0] o_evt,
    // Levels: 0 id, 2:1 line, 3 wake, 4 end, 5 valid, 6 below end
    output var logic [6:0] o_lvl
);
    timeunit 1ns;
    timeprecision 1ns;
    // Core pulse lasts exactly one clock, as the core gives it
    task automatic pulse(input int n);
        @(posedge i_sys_clk) o_evt[n] <= 1'b1;
        @(posedge i_sys_clk) o_evt[n] <= 1'b0;
    endtask
    // Detector level toggles and then holds
    task automatic flip(input int n);
        @(posedge i_sys_clk) o_lvl[n] <= ~o_lvl[n];
    endtask
    // Quiet lines at start
    initial begin
        o_evt = 9'h000;
        o_lvl = 7'h00;
    end
endmodule // uotg_phy_model
`default_nettype wire
